// ### src/sss_pkg.sv
// package for the sleep state sequencer: codes, field layout, timing
package sss_pkg;
	// sleep-type code and state-package layout
	localparam int SLEEP_TYPE_W       = 3;
	localparam int PKG_BYTE_PRIMARY   = 0;
	localparam int PKG_BYTE_SECONDARY = 1;
	localparam int PKG_BYTE_RESERVED  = 2;
	localparam logic [2:0] SLEEP_TYPE_RESET = 3'h0;
	// system states handled here
	localparam logic [1:0] SYS_WORKING = 2'h0;
	localparam logic [1:0] SYS_LIGHT   = 2'h1;
	localparam logic [1:0] SYS_DEEP    = 2'h2;
	// power resource system-level references (one bit per resource)
	localparam logic [1:0] PREF_S0 = 2'h0;
	localparam logic [1:0] PREF_S1 = 2'h1;
	// device states
	localparam logic [1:0] DSTATE_OFF = 2'h3;
	// sequencing timing
	localparam int CLK_PERIOD_NS  = 4;
	localparam int SETTLE_NS      = 40;
	localparam int SETTLE_CYCLES  = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W       = 8;
	// sequencer states, gray along entry and exit up to resume; the resume to work step flips all three bits
	typedef enum logic [2:0] {
		SSS_WORK     = 3'b000,
		SSS_ARMED    = 3'b001,
		SSS_POWERDN  = 3'b011,
		SSS_SLEEP    = 3'b010,
		SSS_POWERUP  = 3'b110,
		SSS_RESUME   = 3'b111
	} sss_state_t;
endpackage

// ### src/sss_ctrl_block.sv
// one power control/status block: sleep-type field, enable strobe, wake flag
`timescale 1ns/1ns
`default_nettype none
module sss_ctrl_block #(
	parameter int TW = sss_pkg::SLEEP_TYPE_W
) (
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          reset,
	// software control write
	input  wire logic          ctl_wr,
	input  wire logic [TW-1:0] ctl_sleep_type_field,
	input  wire logic          ctl_sleep_enable_bit,
	// software status write (write one to clear)
	input  wire logic          sts_wr,
	input  wire logic          sts_wake_clr,
	// hardware wake completion
	input  wire logic          wake_done,
	// outputs
	output logic [TW-1:0]      sleep_type_field_q,
	output logic               sleep_req,
	output logic               wake_status_flag_q
);
	// =====================================================
	// sleep-type field and sleep request
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sleep_type_field_q <= sss_pkg::SLEEP_TYPE_RESET;
		end else if (ctl_wr) begin
			sleep_type_field_q <= ctl_sleep_type_field;
		end
	end

	// sleep-enable reads as a strobe; type and enable land in one write
	assign sleep_req = ctl_wr && ctl_sleep_enable_bit; // R4

	// =====================================================
	// wake status: hardware set wins over the software clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wake_status_flag_q <= 1'b0;
		end else if (wake_done) begin
			wake_status_flag_q <= 1'b1; // R5
		end else if (sts_wr && sts_wake_clr) begin
			wake_status_flag_q <= 1'b0; // R3
		end
	end

	wake_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // R3
		(sts_wr && sts_wake_clr && !wake_done) |=> !wake_status_flag_q)
		else $error("wake flag not cleared by write of one");
endmodule
`default_nettype wire

// ### src/sss_sequencer.sv
// sleep state sequencer: working, light sleep and deep sleep handling
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// (R1) software state package: byte 0 primary code, byte 1 secondary, byte 2 reserved
// (R2) software writes primary sleep type before the secondary sleep type
// (R3) software clears the wake flag by writing one; hardware clears it then
// (R4) type and enable in one write start the hardware sleep sequence
// (R5) hardware sets the wake flag when back in working; software polls it
// (R6) software sets resume pointer before sleeping and clears it after waking
// (R7) light sleep keeps processor context so no cache flush is needed
// (R8) deep sleep may lose context so software writes back dirty lines first
// (R9) working: processors run with context, DRAM read/write, any device state
// (R10) light sleep: processors halted, context kept, DRAM preserved
// (R11) light sleep: resources referenced only by working are off
// (R12) waking from light sleep resumes execution where it stopped
// (R13) deep sleep: processors halted, context may drop, DRAM preserved
// (R14) deep sleep: resources referenced by working or light sleep are off
// (R15) waking from deep sleep starts processor at boot location
// (R16) in sleep a device keeps its state only if all its resources are on
// (R17) an enabled device able to signal wakes the system
// (R18) sleep entry only on software command; return to working is automatic
module sss_sequencer #(
	parameter int                 TW         = sss_pkg::SLEEP_TYPE_W,
	parameter int                 NRES       = 4,
	parameter int                 NDEV       = 4,
	parameter logic [TW-1:0]      LIGHT_CODE = 3'h1,
	parameter logic [TW-1:0]      DEEP_CODE  = 3'h2
) (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	// primary power control and status writes
	input  wire logic                 primary_power_control_wr,
	input  wire logic [TW-1:0]        primary_sleep_type_field,
	input  wire logic                 primary_sleep_enable_bit,
	input  wire logic                 primary_power_status_wr,
	input  wire logic                 primary_wake_status_clr,
	// secondary power control and status writes
	input  wire logic                 secondary_power_control_wr,
	input  wire logic [TW-1:0]        secondary_sleep_type_field,
	input  wire logic                 secondary_sleep_enable_bit,
	input  wire logic                 secondary_power_status_wr,
	input  wire logic                 secondary_wake_status_clr,
	// power resources: reference level per resource, 0 working, 1 light sleep
	input  wire logic [NRES-1:0]      res_ref_light,
	// devices: resources each needs for its current state, and wake ability
	input  wire logic [NDEV*NRES-1:0] dev_res_need,
	input  wire logic [NDEV-1:0]      dev_wake_enable,
	input  wire logic [NDEV-1:0]      dev_wake_capable,
	input  wire logic [NDEV-1:0]      dev_wake_event,
	// status to software
	output logic                      primary_wake_status_flag,
	output logic                      secondary_wake_status_flag,
	output logic [TW-1:0]             primary_sleep_type_q,
	output logic [TW-1:0]             secondary_sleep_type_q,
	// processor and memory control
	output logic                      cpu_run_q,
	output logic                      cpu_ctx_keep_q,
	output logic                      cpu_boot_reset_q,
	output logic                      dram_self_refresh_q,
	// power resources and device status
	output logic [NRES-1:0]           res_on_q,
	output logic [NDEV-1:0]           dev_forced_off_q,
	output logic [1:0]                sys_state_q
);
	// =====================================================
	// control blocks
	logic prim_req;
	logic sec_req;
	logic wake_done;

	sss_ctrl_block #(.TW(TW)) u_prim (
		.clk_sys              (clk_sys),
		.reset                (reset),
		.ctl_wr               (primary_power_control_wr),
		.ctl_sleep_type_field (primary_sleep_type_field),
		.ctl_sleep_enable_bit (primary_sleep_enable_bit),
		.sts_wr               (primary_power_status_wr),
		.sts_wake_clr         (primary_wake_status_clr),
		.wake_done            (wake_done),
		.sleep_type_field_q   (primary_sleep_type_q),
		.sleep_req            (prim_req),
		.wake_status_flag_q   (primary_wake_status_flag)
	);

	sss_ctrl_block #(.TW(TW)) u_sec (
		.clk_sys              (clk_sys),
		.reset                (reset),
		.ctl_wr               (secondary_power_control_wr),
		.ctl_sleep_type_field (secondary_sleep_type_field),
		.ctl_sleep_enable_bit (secondary_sleep_enable_bit),
		.sts_wr               (secondary_power_status_wr),
		.sts_wake_clr         (secondary_wake_status_clr),
		.wake_done            (wake_done),
		.sleep_type_field_q   (secondary_sleep_type_q),
		.sleep_req            (sec_req),
		.wake_status_flag_q   (secondary_wake_status_flag)
	);

	// =====================================================
	// decoding
	function automatic logic [1:0] code_to_state(input logic [TW-1:0] c);
		if (c == LIGHT_CODE) begin
			code_to_state = sss_pkg::SYS_LIGHT;
		end else if (c == DEEP_CODE) begin
			code_to_state = sss_pkg::SYS_DEEP;
		end else begin
			code_to_state = sss_pkg::SYS_WORKING;
		end
	endfunction

	// resources a target state leaves on
	function automatic logic [NRES-1:0] keep_mask(input logic [1:0] st);
		if (st == sss_pkg::SYS_LIGHT) begin
			keep_mask = res_ref_light; // R11
		end else if (st == sss_pkg::SYS_DEEP) begin
			keep_mask = '0; // R14
		end else begin
			keep_mask = '1;
		end
	endfunction

	// =====================================================
	// wake detect
	logic [NDEV-1:0] dev_can_wake;
	logic            wake_any;

	genvar gd;
	generate
		for (gd = 0; gd < NDEV; gd++) begin : g_dev
			assign dev_can_wake[gd] = dev_wake_enable[gd] && dev_wake_capable[gd] &&
				!dev_forced_off_q[gd] && dev_wake_event[gd]; // R17
		end
	endgenerate

	assign wake_any = |dev_can_wake;

	// =====================================================
	// sequencer
	localparam int SETTLE_W_L = sss_pkg::SETTLE_W;
	localparam logic [SETTLE_W_L-1:0] SETTLE_LAST = SETTLE_W_L'(sss_pkg::SETTLE_CYCLES - 1);
	sss_pkg::sss_state_t      st_q;
	logic [1:0]               target_q;
	logic [SETTLE_W_L-1:0]    settle_q;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q     <= sss_pkg::SSS_WORK;
			target_q <= sss_pkg::SYS_WORKING;
			settle_q <= '0;
		end else begin
			unique case (st_q)
				sss_pkg::SSS_WORK: begin
					settle_q <= '0;
					if (prim_req && code_to_state(primary_sleep_type_field) !=
						sss_pkg::SYS_WORKING) begin // R18
						target_q <= code_to_state(primary_sleep_type_field);
						st_q     <= sss_pkg::SSS_ARMED;
					end
				end
				sss_pkg::SSS_ARMED: begin
					// secondary block completes the request; primary came first
					if (sec_req) begin // R4
						st_q <= sss_pkg::SSS_POWERDN;
					end
				end
				sss_pkg::SSS_POWERDN: begin
					settle_q <= settle_q + 1'b1;
					if (settle_q == SETTLE_LAST) begin
						settle_q <= '0;
						st_q     <= sss_pkg::SSS_SLEEP;
					end
				end
				sss_pkg::SSS_SLEEP: begin
					if (wake_any) begin // R18
						st_q <= sss_pkg::SSS_POWERUP;
					end
				end
				sss_pkg::SSS_POWERUP: begin
					settle_q <= settle_q + 1'b1;
					if (settle_q == SETTLE_LAST) begin
						settle_q <= '0;
						st_q     <= sss_pkg::SSS_RESUME;
					end
				end
				sss_pkg::SSS_RESUME: begin
					st_q     <= sss_pkg::SSS_WORK;
					target_q <= sss_pkg::SYS_WORKING;
				end
				default: begin
					st_q <= sss_pkg::SSS_WORK;
				end
			endcase
		end
	end

	assign wake_done = (st_q == sss_pkg::SSS_RESUME); // R5

	// =====================================================
	// processor and DRAM control
	logic sleeping;
	assign sleeping = (st_q == sss_pkg::SSS_POWERDN) || (st_q == sss_pkg::SSS_SLEEP) ||
		(st_q == sss_pkg::SSS_POWERUP);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cpu_run_q           <= 1'b1;
			cpu_ctx_keep_q      <= 1'b1;
			cpu_boot_reset_q    <= 1'b0;
			dram_self_refresh_q <= 1'b0;
		end else begin
			cpu_run_q           <= !sleeping; // R9 R10 R13
			dram_self_refresh_q <= sleeping; // R10 R13
			cpu_ctx_keep_q      <= !(sleeping && target_q == sss_pkg::SYS_DEEP); // R10 R13
			// deep wake restarts at boot; light wake continues in place
			cpu_boot_reset_q    <= (st_q == sss_pkg::SSS_POWERUP) &&
				(target_q == sss_pkg::SYS_DEEP); // R12 R15
		end
	end

	// =====================================================
	// power resources and device states
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			res_on_q <= '1;
		end else if (st_q == sss_pkg::SSS_POWERDN || st_q == sss_pkg::SSS_SLEEP) begin
			res_on_q <= keep_mask(target_q); // R11 R14
		end else begin
			res_on_q <= '1; // R9
		end
	end

	genvar gk;
	generate
		for (gk = 0; gk < NDEV; gk++) begin : g_off
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					dev_forced_off_q[gk] <= 1'b0;
				end else begin
					dev_forced_off_q[gk] <= sleeping &&
						((dev_res_need[gk*NRES +: NRES] & ~res_on_q) != '0); // R16
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sys_state_q <= sss_pkg::SYS_WORKING;
		end else begin
			sys_state_q <= (st_q == sss_pkg::SSS_SLEEP) ? target_q : sss_pkg::SYS_WORKING;
		end
	end

	// =====================================================
	// checks
	no_self_sleep_a: assert property (@(posedge clk_sys) disable iff (reset) // R18
		(st_q == sss_pkg::SSS_WORK && !prim_req) |=> st_q == sss_pkg::SSS_WORK)
		else $error("sleep entered without a software request");
	sleep_halts_cpu_a: assert property (@(posedge clk_sys) disable iff (reset) // R10 R13
		(st_q == sss_pkg::SSS_SLEEP) |-> (!cpu_run_q && dram_self_refresh_q))
		else $error("processor running or DRAM unprotected in sleep");
	light_keeps_ctx_a: assert property (@(posedge clk_sys) disable iff (reset) // R10 R12
		(st_q == sss_pkg::SSS_SLEEP && target_q == sss_pkg::SYS_LIGHT) |-> cpu_ctx_keep_q)
		else $error("context lost in light sleep");
	deep_resources_a: assert property (@(posedge clk_sys) disable iff (reset) // R14
		(st_q == sss_pkg::SSS_SLEEP && $past(st_q) == sss_pkg::SSS_SLEEP &&
		target_q == sss_pkg::SYS_DEEP) |-> res_on_q == '0)
		else $error("resource left on in deep sleep");
	light_resources_a: assert property (@(posedge clk_sys) disable iff (reset) // R11
		(st_q == sss_pkg::SSS_SLEEP && $past(st_q) == sss_pkg::SSS_SLEEP &&
		target_q == sss_pkg::SYS_LIGHT) |-> (res_on_q & ~res_ref_light) == '0)
		else $error("working-only resource on in light sleep");
	wake_returns_a: assert property (@(posedge clk_sys) disable iff (reset) // R17
		(st_q == sss_pkg::SSS_SLEEP && wake_any) |-> ##[1:40] wake_done)
		else $error("wake event did not return to working");
	wake_flag_set_a: assert property (@(posedge clk_sys) disable iff (reset) // R5
		wake_done |=> (primary_wake_status_flag && secondary_wake_status_flag))
		else $error("wake flag not set on return");
	deep_boot_a: assert property (@(posedge clk_sys) disable iff (reset) // R15
		(st_q == sss_pkg::SSS_POWERUP && target_q == sss_pkg::SYS_DEEP) |=> cpu_boot_reset_q)
		else $error("deep wake did not restart at boot");
	working_run_a: assert property (@(posedge clk_sys) disable iff (reset) // R9
		(st_q == sss_pkg::SSS_WORK && $past(st_q) == sss_pkg::SSS_WORK) |->
		(cpu_run_q && res_on_q == '1))
		else $error("working state without full power");
	dev_off_a: assert property (@(posedge clk_sys) disable iff (reset) // R16
		(st_q == sss_pkg::SSS_WORK && $past(st_q) == sss_pkg::SSS_WORK) |->
		dev_forced_off_q == '0)
		else $error("device forced off while working");
endmodule
`default_nettype wire

// ### dv/sss_sequencer_bench.sv
// self-checking bench for the sleep state sequencer
`timescale 1ns/1ns
`default_nettype none
module sss_sequencer_bench;
	// ==========================================
	// stimulus and observed signals
	logic        clk_sys;
	logic        reset;
	logic        p_wr;
	logic        s_wr;
	logic [2:0]  p_type;
	logic [2:0]  s_type;
	logic        p_en;
	logic        s_en;
	logic        sts_wr;
	logic        sts_clr;
	logic [3:0]  wake_ev;
	logic [3:0]  capable;
	logic        p_flag;
	logic        s_flag;
	logic [2:0]  p_type_q;
	logic [2:0]  s_type_q;
	logic        run_q;
	logic        ctx_q;
	logic        boot_q;
	logic        sr_q;
	logic [3:0]  res_q;
	logic [3:0]  off_q;
	logic [1:0]  state_q;
	int          error_cnt;
	int          samples_checked;

	// ==========================================
	// design under test
	sss_sequencer sss_sequencer_i (
		.clk_sys                    (clk_sys),
		.reset                      (reset),
		.primary_power_control_wr   (p_wr),
		.primary_sleep_type_field   (p_type),
		.primary_sleep_enable_bit   (p_en),
		.primary_power_status_wr    (sts_wr),
		.primary_wake_status_clr    (sts_clr),
		.secondary_power_control_wr (s_wr),
		.secondary_sleep_type_field (s_type),
		.secondary_sleep_enable_bit (s_en),
		.secondary_power_status_wr  (sts_wr),
		.secondary_wake_status_clr  (sts_clr),
		.res_ref_light              (4'h3),
		.dev_res_need               (16'h2041),
		.dev_wake_enable            (4'h6),
		.dev_wake_capable           (capable),
		.dev_wake_event             (wake_ev),
		.primary_wake_status_flag   (p_flag),
		.secondary_wake_status_flag (s_flag),
		.primary_sleep_type_q       (p_type_q),
		.secondary_sleep_type_q     (s_type_q),
		.cpu_run_q                  (run_q),
		.cpu_ctx_keep_q             (ctx_q),
		.cpu_boot_reset_q           (boot_q),
		.dram_self_refresh_q        (sr_q),
		.res_on_q                   (res_q),
		.dev_forced_off_q           (off_q),
		.sys_state_q                (state_q)
	);

	// ==========================================
	// common tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one control write with type and enable together
	task automatic ctl_write(input logic sec, input logic [2:0] code);
		@(posedge clk_sys);
		p_wr <= !sec;
		s_wr <= sec;
		p_type <= code;
		s_type <= code;
		@(posedge clk_sys);
		p_wr <= 1'b0;
		s_wr <= 1'b0;
	endtask

	task automatic wake_pulse(input logic [3:0] m, input logic [3:0] cap);
		@(posedge clk_sys);
		wake_ev <= m;
		capable <= cap;
		@(posedge clk_sys);
		wake_ev <= 4'h0;
		capable <= 4'hf;
	endtask

	task automatic working_values(input logic fl);
		check("primary wake flag", p_flag, fl);
		check("secondary wake flag", s_flag, fl);
		check("cpu run", run_q, 1'b1);
		check("context kept", ctx_q, 1'b1);
		check("self refresh", sr_q, 1'b0);
		check("resources on", res_q, 4'hf);
		check("devices forced off", off_q, 4'h0);
		check("system state", state_q, 2'h0);
	endtask

	// ==========================================
	// scenarios
	task automatic no_entry;
		ctl_write(1'b1, 3'h1);
		repeat (30) @(negedge clk_sys);
		check("secondary alone", state_q, 2'h0);
		ctl_write(1'b0, 3'h3);
		@(negedge clk_sys);
		check("primary type stored", p_type_q, 3'h3);
		ctl_write(1'b1, 3'h3);
		repeat (30) @(negedge clk_sys);
		check("non-sleep code", run_q, 1'b1);
		check("secondary type stored", s_type_q, 3'h3);
	endtask

	task automatic sleep_cycle(input logic [2:0] code, input logic deep, input logic [3:0] res_exp,
		input logic [3:0] off_exp);
		int   n;
		logic boot_seen;
		@(posedge clk_sys);
		sts_wr <= 1'b1;
		@(posedge clk_sys);
		sts_wr <= 1'b0;
		@(negedge clk_sys);
		check("primary flag cleared", p_flag, 1'b0);
		check("secondary flag cleared", s_flag, 1'b0);
		ctl_write(1'b0, code);
		@(negedge clk_sys);
		check("primary type", p_type_q, code);
		check("armed still runs", run_q, 1'b1);
		ctl_write(1'b1, code);
		// powerdown settles before the sleep state shows
		n = 0;
		while (state_q === 2'h0 && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
		check("entry cycles", n, sss_pkg::SETTLE_CYCLES + 2);
		check("cpu halted", run_q, 1'b0);
		check("context kept", ctx_q, !deep);
		check("dram self refresh", sr_q, 1'b1);
		check("resources on", res_q, res_exp);
		check("devices forced off", off_q, off_exp);
		check("sleep state", state_q, deep ? 2'h2 : 2'h1);
		// disabled, incapable and forced-off devices must not wake the system
		wake_pulse(4'hf, 4'hb);
		repeat (30) @(negedge clk_sys);
		check("blocked wake", run_q, 1'b0);
		wake_pulse(4'h4, 4'hf);
		n = 0;
		boot_seen = 1'b0;
		while (n < 60) begin
			@(negedge clk_sys);
			if (boot_q === 1'b1) begin
				boot_seen = 1'b1;
			end
			n++;
		end
		check("boot restart", boot_seen, deep);
		working_values(1'b1);
	endtask

	// ==========================================
	// clock, reset, sequence and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = !clk_sys;
	end

	initial begin
		reset = 1'b1;
		p_wr = 1'b0;
		s_wr = 1'b0;
		p_type = 3'h0;
		s_type = 3'h0;
		p_en = 1'b1;
		s_en = 1'b1;
		sts_wr = 1'b0;
		sts_clr = 1'b1;
		wake_ev = 4'h0;
		capable = 4'hf;
		error_cnt = 0;
		samples_checked = 0;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		@(negedge clk_sys);
		working_values(1'b0);
		check("reset primary type", p_type_q, 3'h0);
		check("reset boot", boot_q, 1'b0);
		no_entry();
		sleep_cycle(3'h1, 1'b0, 4'h3, 4'h2);
		sleep_cycle(3'h2, 1'b1, 4'h0, 4'hb);
		wrap_up();
	end

	initial begin
		#40000;
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire
